// *** design/spmp_pkg.sv ***
// Functional notes
// - slave transfer-complete wakes device from halt
// - second completion before flag clear sets overrun
// - halt wake needs select low at entry
// - one shared request, gated by global mask
// - enable bit gates done, fault, overrun requests
// - port enable bit, cleared by fault
// - master bit, cleared by fault
// - rate bits divide clock in master mode
// - polarity bit sets clock idle level
// - phase bit picks first capture edge
// - done flag cleared by status then data access
// - data writes ignored while done flag set and status not yet accessed
// - data write during transfer sets collision flag
// - overrun set on new byte while done set
// - fault flag: select low in master mode
// - output disable bit gates data output pin
// - soft select replaces select pin in slave mode, disables fault check in master mode
// - master data write starts transfer
// - received byte buffered at transfer end
// - overrun keeps first byte after clear
// - fault blocks setting enable and master bits
// - collision flag raises no request
// - bytes shifted most significant bit first
package spmp_pkg;
    localparam logic [3:0] SPMP_ADDR_DATA = 4'h0;
    localparam logic [3:0] SPMP_ADDR_CTRL = 4'h4;
    localparam logic [3:0] SPMP_ADDR_STAT = 4'h8;
    localparam int SPMP_CTL_IRQ_EN = 7;
    localparam int SPMP_CTL_PORT_EN = 6;
    localparam int SPMP_CTL_RATE2 = 5;
    localparam int SPMP_CTL_MASTER = 4;
    localparam int SPMP_CTL_CLOCK_IDLE_LEVEL = 3;
    localparam int SPMP_CTL_CLOCK_CAPTURE_PHASE = 2;
    localparam int SPMP_CTL_RATE1 = 1;
    localparam int SPMP_CTL_RATE0 = 0;
    localparam int SPMP_ST_DONE = 7;
    localparam int SPMP_ST_WRITE_COLLISION_FLAG = 6;
    localparam int SPMP_ST_OVR = 5;
    localparam int SPMP_ST_MODE_FAULT_FLAG = 4;
    localparam int SPMP_ST_SOD = 2;
    localparam int SPMP_ST_SSM = 1;
    localparam int SPMP_ST_SSI = 0;
    localparam logic [7:0] SPMP_CTRL_RESET = 8'h00;
    localparam logic [2:0] SPMP_CSR_SW_RESET = 3'h0;
    localparam int SPMP_CLK_MHZ = 50;
    localparam int SPMP_BITS = 8;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
    } spmp_pins_out_type;

    typedef struct packed {
        logic sck_i;
        logic mosi_i;
        logic miso_i;
        logic ss_n_i;
    } spmp_pins_in_type;
endpackage

// *** design/spmp_port.sv ***
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module spmp_port (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [3:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial pins
    input wire spmp_pkg::spmp_pins_in_type pins_in,
    output spmp_pkg::spmp_pins_out_type pins_out,
    // cpu side
    input wire logic cpu_irq_masked,
    input wire logic halted,
    output logic irq_req,
    output logic wake_halt,
    output logic wake_wait,
    output logic port_active
);
    import spmp_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT
    } spmp_state_type;

    logic [7:0] ctrl_r;
    logic done_r, write_collision_flag_r, ovr_r, mode_fault_flag_r;
    logic sod_r, ssm_r, ssi_r;
    logic [7:0] shift_r;
    logic [7:0] rxbuf_r;
    logic [3:0] edges_r;
    logic [6:0] div_r;
    logic sck_r;
    logic samp_r;
    logic sck_in_d_r;
    logic done_seen_r;
    logic mode_fault_flag_seen_r;
    logic write_collision_flag_seen_r;
    logic halt_sel_r;
    logic halt_d_r;
    spmp_state_type state_r;

    logic acc, wr, rd, a_data, a_ctrl, a_stat;
    logic master, enabled, clock_idle_level, clock_capture_phase, sel_n, ss_eff_n;
    logic [6:0] half_div;
    logic tick, sck_edge, lead_edge, cap_edge, xfer_end;
    logic slave_active, data_wr_ok, done_clr;
    logic rx_live, rx_last;

    assign acc = psel && penable && clk_en;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign a_data = paddr == SPMP_ADDR_DATA;
    assign a_ctrl = paddr == SPMP_ADDR_CTRL;
    assign a_stat = paddr == SPMP_ADDR_STAT;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(a_data || a_ctrl || a_stat);

    assign master = ctrl_r[SPMP_CTL_MASTER];
    assign enabled = ctrl_r[SPMP_CTL_PORT_EN];
    assign clock_idle_level = ctrl_r[SPMP_CTL_CLOCK_IDLE_LEVEL];
    assign clock_capture_phase = ctrl_r[SPMP_CTL_CLOCK_CAPTURE_PHASE];
    assign ss_eff_n = ssm_r ? ssi_r : pins_in.ss_n_i;

    // half period of the serial clock in cpu cycles
    always_comb begin
        unique case ({ctrl_r[SPMP_CTL_RATE2], ctrl_r[SPMP_CTL_RATE1],
                      ctrl_r[SPMP_CTL_RATE0]})
            3'h4: half_div = 7'h02;
            3'h0: half_div = 7'h04;
            3'h1: half_div = 7'h08;
            3'h6: half_div = 7'h10;
            3'h2: half_div = 7'h20;
            3'h3: half_div = 7'h40;
            default: half_div = 7'h04;
        endcase
    end

    assign tick = master && state_r == ST_SHIFT && div_r == half_div - 7'h01;
    assign slave_active = !master && enabled && !ss_eff_n;
    assign sck_edge = master ? tick
        : (slave_active && pins_in.sck_i != sck_in_d_r);
    // leading edges are even-numbered transitions (edges_r counts from 0)
    assign lead_edge = sck_edge && !edges_r[0];
    assign cap_edge = sck_edge && (edges_r[0] == clock_capture_phase);
    assign xfer_end = sck_edge && edges_r == 4'hf;
    assign sel_n = pins_in.ss_n_i;
    assign rx_live = master ? pins_in.miso_i : pins_in.mosi_i;
    // with phase 1 the last bit is captured on the closing edge itself
    assign rx_last = cap_edge ? rx_live : samp_r;
    assign data_wr_ok = wr && a_data && !(done_r && !done_seen_r);
    assign done_clr = acc && a_data && done_r && done_seen_r;

    // transfer state and divider
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_r <= ST_IDLE;
            div_r <= 7'h00;
            edges_r <= 4'h0;
            sck_r <= 1'b0;
            sck_in_d_r <= 1'b0;
        end else if (clk_en && !halted) begin
            sck_in_d_r <= pins_in.sck_i;
            if (tick)
                div_r <= 7'h00;
            else if (state_r == ST_SHIFT && master)
                div_r <= div_r + 7'h01;
            if (sck_edge)
                edges_r <= edges_r + 4'h1;
            if (master && tick)
                sck_r <= !sck_r;
            if (!enabled || (!master && ss_eff_n)) begin
                state_r <= ST_IDLE;
                edges_r <= 4'h0;
                sck_r <= 1'b0;
            end else if (state_r == ST_IDLE) begin
                if ((master && data_wr_ok) || (!master && sck_edge)) begin
                    state_r <= ST_SHIFT;
                    div_r <= 7'h00;
                end
            end else if (xfer_end) begin
                state_r <= ST_IDLE;
                edges_r <= 4'h0;
            end
        end else if (halted && !master) begin
            // slave keeps clocking from the far master while halted
            sck_in_d_r <= pins_in.sck_i;
            if (sck_edge)
                edges_r <= edges_r + 4'h1;
            if (state_r == ST_IDLE && sck_edge && halt_sel_r)
                state_r <= ST_SHIFT;
            else if (xfer_end) begin
                state_r <= ST_IDLE;
                edges_r <= 4'h0;
            end
        end
    end

    // slave mode begins on the first edge, so it counts it already
    wire first_slave = !master && state_r == ST_IDLE && sck_edge;

    // shift register, msb first
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            shift_r <= 8'h00;
            samp_r <= 1'b0;
        end else if (clk_en || halted) begin
            if (data_wr_ok && state_r == ST_IDLE)
                shift_r <= pwdata[7:0];
            else if (cap_edge || (first_slave && !clock_capture_phase))
                samp_r <= master ? pins_in.miso_i : pins_in.mosi_i;
            else if (sck_edge && !cap_edge && edges_r != 4'h0)
                shift_r <= {shift_r[6:0], samp_r};
            else if (xfer_end)
                shift_r <= {shift_r[6:0], samp_r};
        end
    end

    // receive buffer: first byte after clear is kept
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            rxbuf_r <= 8'h00;
        else if (xfer_end && !done_r)
            rxbuf_r <= {shift_r[6:0], rx_last};
    end

    // control register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            ctrl_r <= SPMP_CTRL_RESET;
        else if (clk_en && !halted) begin
            if (master && enabled && !ssm_r && !sel_n) begin
                ctrl_r[SPMP_CTL_PORT_EN] <= 1'b0;
                ctrl_r[SPMP_CTL_MASTER] <= 1'b0;
            end else if (wr && a_ctrl) begin
                ctrl_r <= pwdata[7:0];
                if (mode_fault_flag_r && !mode_fault_flag_seen_r) begin
                    ctrl_r[SPMP_CTL_PORT_EN] <= 1'b0;
                    ctrl_r[SPMP_CTL_MASTER] <= 1'b0;
                end
            end
        end
    end

    // status flags; hardware set wins over software clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            done_r <= 1'b0;
            ovr_r <= 1'b0;
            write_collision_flag_r <= 1'b0;
            mode_fault_flag_r <= 1'b0;
            done_seen_r <= 1'b0;
            mode_fault_flag_seen_r <= 1'b0;
            write_collision_flag_seen_r <= 1'b0;
            {sod_r, ssm_r, ssi_r} <= SPMP_CSR_SW_RESET;
        end else if (clk_en || halted) begin
            if (xfer_end && done_r)
                ovr_r <= 1'b1;
            else if (rd && a_stat)
                ovr_r <= 1'b0;
            if (xfer_end)
                done_r <= 1'b1;
            else if (done_clr)
                done_r <= 1'b0;
            if (acc && a_stat && done_r)
                done_seen_r <= 1'b1;
            else if (done_clr || !done_r)
                done_seen_r <= 1'b0;
            if (wr && a_data && state_r == ST_SHIFT)
                write_collision_flag_r <= 1'b1;
            else if (acc && a_data && write_collision_flag_seen_r)
                write_collision_flag_r <= 1'b0;
            if (acc && a_stat && write_collision_flag_r)
                write_collision_flag_seen_r <= 1'b1;
            else if (!write_collision_flag_r || (acc && a_data))
                write_collision_flag_seen_r <= 1'b0;
            if (master && enabled && !ssm_r && !sel_n)
                mode_fault_flag_r <= 1'b1;
            else if (wr && a_ctrl && mode_fault_flag_seen_r)
                mode_fault_flag_r <= 1'b0;
            if (rd && a_stat && mode_fault_flag_r)
                mode_fault_flag_seen_r <= 1'b1;
            else if (!mode_fault_flag_r)
                mode_fault_flag_seen_r <= 1'b0;
            if (wr && a_stat)
                {sod_r, ssm_r, ssi_r} <= pwdata[2:0];
        end
    end

    // select level latched on entry to halt
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            halt_d_r <= 1'b0;
            halt_sel_r <= 1'b0;
        end else begin
            halt_d_r <= halted;
            if (halted && !halt_d_r)
                halt_sel_r <= !master && enabled && !ss_eff_n;
        end
    end

    // read data and irq outputs
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            prdata <= 32'h0000_0000;
        else if (psel && !penable) begin
            if (paddr == SPMP_ADDR_DATA)
                prdata <= {24'h00_0000, rxbuf_r};
            else if (paddr == SPMP_ADDR_CTRL)
                prdata <= {24'h00_0000, ctrl_r};
            else if (paddr == SPMP_ADDR_STAT)
                prdata <= {24'h00_0000, done_r, write_collision_flag_r, ovr_r, mode_fault_flag_r,
                           1'b0, sod_r, ssm_r, ssi_r};
            else
                prdata <= 32'h0000_0000;
        end
    end

    wire any_evt = done_r || mode_fault_flag_r || ovr_r;
    assign irq_req = ctrl_r[SPMP_CTL_IRQ_EN] && any_evt
        && !cpu_irq_masked;
    assign wake_wait = irq_req;
    assign wake_halt = ctrl_r[SPMP_CTL_IRQ_EN] && done_r && halted
        && halt_sel_r;
    assign port_active = enabled;

    always_comb begin
        pins_out.sck_o = (master && state_r == ST_SHIFT) ? sck_r ^ clock_idle_level
            : clock_idle_level;
        pins_out.sck_oe = enabled && master;
        pins_out.mosi_o = shift_r[7];
        pins_out.mosi_oe = enabled && master && !sod_r;
        pins_out.miso_o = shift_r[7];
        pins_out.miso_oe = enabled && !master && !sod_r && !ss_eff_n;
    end
endmodule

// *** verification/spmp_slave_model.sv ***
`timescale 1ns/100ps
module spmp_slave_model (
    // serial side
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_n,
    input wire logic clock_capture_phase,
    // byte side
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    int e = 0;
    initial miso = 1'b0;
    always @(negedge sel_n) begin
        e = 0;
        miso = tx_byte[7];
    end
    // released line shows the inverse of its last level
    always @(posedge sel_n) miso = ~miso;
    always @(sck) begin
        if (!sel_n && e < 16) begin
            e = e + 1;
            if (e[0] != clock_capture_phase)
                rx_byte = {rx_byte[6:0], mosi};
            else if (e < 16)
                miso = tx_byte[7 - (e - clock_capture_phase) / 2];
        end
    end
endmodule

// *** verification/spmp_port_assertions.sv ***
`timescale 1ns/100ps
module spmp_port_assertions (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [3:0] paddr,
    input wire logic [31:0] prdata,
    input wire spmp_pkg::spmp_pins_out_type pins_out,
    input wire logic cpu_irq_masked,
    input wire logic irq_req,
    input wire logic wake_wait,
    input wire logic port_active
);
    import spmp_pkg::*;
    logic acc;
    logic rd;
    assign acc = psel && penable && clk_en;
    assign rd = acc && !pwrite;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (reset);
    sequence done_rd;
        rd && paddr == SPMP_ADDR_STAT && prdata[7:4] == 4'h8;
    endsequence
    chk_irq_mask: assert property (irq_req |-> !cpu_irq_masked)
        else $error("irq raised while masked");
    chk_wait_irq: assert property (wake_wait == irq_req)
        else $error("wait wake differs from irq");
    chk_pins_idle: assert property (!port_active |->
        !(pins_out.sck_oe || pins_out.mosi_oe || pins_out.miso_oe))
        else $error("pins driven while port disabled");
    chk_data_dir: assert property (
        !(pins_out.mosi_oe && pins_out.miso_oe))
        else $error("both data lines driven");
    chk_sck_dir: assert property (
        pins_out.sck_oe |-> !pins_out.miso_oe)
        else $error("master drives its input line");
    chk_sck_rate: assert property (
        pins_out.sck_oe && $changed(pins_out.sck_o)
        |=> $stable(pins_out.sck_o))
        else $error("serial clock half period below two");
    chk_done_clear: assert property (done_rd ##[1:4]
        (acc && paddr == SPMP_ADDR_DATA) |=> !irq_req)
        else $error("done request kept after clear");
    chk_en_readback: assert property (
        rd && paddr == SPMP_ADDR_CTRL |->
        prdata[SPMP_CTL_PORT_EN] == $past(port_active))
        else $error("enable bit differs from port state");
    cov_irq: cover property ($rose(irq_req));
    cov_fault: cover property ($fell(port_active));
    cov_clear: cover property (done_rd);
endmodule
bind spmp_port spmp_port_assertions chk_u (.mclk(mclk), .reset(reset),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pins_out(pins_out),
    .cpu_irq_masked(cpu_irq_masked), .irq_req(irq_req),
    .wake_wait(wake_wait), .port_active(port_active));

// *** verification/spmp_port_tb.sv ***
`timescale 1ns/100ps
module spmp_port_tb;
    import spmp_pkg::*;
    localparam logic [3:0] DR = SPMP_ADDR_DATA;
    localparam logic [3:0] CR = SPMP_ADDR_CTRL;
    localparam logic [3:0] SR = SPMP_ADDR_STAT;
    logic mclk, reset, psel, penable, pwrite, masked, ss_n, sel_n;
    logic pready, pslverr, serr, irq_req, port_active, clock_idle_level, clock_capture_phase;
    logic sck_w, mosi_w, miso_w;
    logic [3:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [7:0] stx, srx;
    spmp_pins_in_type pin_i;
    spmp_pins_out_type pin_o;
    int errors = 0;
    int check_count = 0;
    int n;
    logic [2:0] rc [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
    int dv [6] = '{4, 8, 16, 32, 64, 128};
    assign sck_w = pin_o.sck_oe ? pin_o.sck_o : 1'b0;
    assign mosi_w = pin_o.mosi_oe ? pin_o.mosi_o : 1'b0;
    assign pin_i = {sck_w, mosi_w, miso_w, ss_n};
    spmp_port dut_u (.mclk(mclk), .reset(reset), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins_in(pin_i), .pins_out(pin_o),
        .cpu_irq_masked(masked), .halted(1'b0), .irq_req(irq_req),
        .wake_halt(), .wake_wait(), .port_active(port_active));
    spmp_slave_model slv_u (.sck(sck_w), .mosi(mosi_w), .sel_n(sel_n),
        .clock_capture_phase(clock_capture_phase), .tx_byte(stx), .miso(miso_w), .rx_byte(srx));
    task automatic chk(input string s, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [3:0] a,
                       input logic [7:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdv = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        chk("prdata", e, rdv);
    endtask
    task automatic xfer(input logic [7:0] m, input logic coll);
        sel_n <= 1'b0;
        wr(DR, m);
        if (coll)
            wr(DR, ~m);
        n = 0;
        while (irq_req !== 1'b1 && n < 3000) begin
            @(posedge mclk);
            n++;
        end
        sel_n <= 1'b1;
        chk("slave_rx", {24'h0, m}, {24'h0, srx});
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        complete_run();
    end
    initial begin
        {reset, ss_n, sel_n} = 3'h7;
        {psel, penable, pwrite, masked, clock_idle_level, clock_capture_phase} = 6'h0;
        {paddr, pwdata, stx} = 44'h0;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        rd(CR, 32'h0);
        rd(SR, 32'h0);
        rd(4'hc, 32'h0);
        chk("slverr", 32'h1, serr);
        for (int i = 0; i < 6; i++) begin
            wr(CR, 8'h00);
            clock_idle_level = i[0];
            clock_capture_phase = i[1];
            wr(CR, {2'h3, rc[i][2], 1'b1, clock_idle_level, clock_capture_phase, rc[i][1:0]});
            @(negedge mclk);
            chk("sck_idle", clock_idle_level, pin_o.sck_o);
            stx = 8'h3c ^ 8'(i);
            xfer(8'ha5 ^ 8'(i), 1'b0);
            chk("cycles", 32'h1, n >= 8*dv[i]-2 && n <= 8*dv[i]+4);
            rd(SR, 32'h80);
            rd(DR, {24'h0, stx});
            rd(SR, 32'h0);
        end
        wr(CR, 8'h00);
        {clock_idle_level, clock_capture_phase} = 2'h0;
        wr(CR, 8'hd0);
        stx = 8'h96;
        xfer(8'h5a, 1'b1);
        wr(DR, 8'h77);
        repeat (6) @(posedge mclk);
        chk("sck_still", 32'h0, pin_o.sck_o);
        masked <= 1'b1;
        @(negedge mclk);
        chk("irq", 32'h0, irq_req);
        masked <= 1'b0;
        wr(CR, 8'h50);
        @(negedge mclk);
        chk("irq", 32'h0, irq_req);
        wr(CR, 8'hd0);
        @(negedge mclk);
        chk("irq", 32'h1, irq_req);
        rd(SR, 32'hc0);
        rd(DR, {24'h0, stx});
        rd(SR, 32'h0);
        wr(SR, 8'h04);
        @(negedge mclk);
        chk("mosi_oe", 32'h0, pin_o.mosi_oe);
        wr(SR, 8'h00);
        ss_n <= 1'b0;
        repeat (4) @(posedge mclk);
        ss_n <= 1'b1;
        @(negedge mclk);
        chk("active", 32'h0, port_active);
        chk("irq", 32'h1, irq_req);
        wr(CR, 8'hd0);
        rd(CR, 32'h80);
        rd(SR, 32'h10);
        wr(CR, 8'hd0);
        rd(SR, 32'h0);
        rd(CR, 32'hd0);
        complete_run();
    end
endmodule
